/* inc/interval_timer_consts.vh */
// Purpose: Constants for the 16-bit interval timer.
// Assumes: Control word index 15 holds control bit 0 (bit 0 is high order).
// Notes: Control bit n sits at vector index 15-n.
`ifndef INTERVAL_TIMER_CONSTS_VH
`define INTERVAL_TIMER_CONSTS_VH

`define WORD_W 16
`define COUNT_MAX 16'hFFFF
`define COUNT_ZERO 16'h0000

// Control register field positions (vector index)
`define CTL_EXT_LOAD 6
`define CTL_OVF_LOAD 5
`define CTL_OVF_STOP 4
`define CTL_READ_SEL 3
`define CTL_AUX_LOAD 2
`define CTL_AUX_ZERO 1
`define CTL_HALT 0

// Bits 0-8 of the control word are unused and read as zero
`define CTL_USED_MASK 16'h007F
`define CTL_RESET 16'h0001
`define PRESET_RESET 16'h0000
`define SAMPLE_RESET 16'h0000

// Timebase
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICK_CNT_W 6
`define TICK_LAST 6'h31

`endif

/* rtl/interval_timer_16bit.v */
// Purpose: 16-bit programmable interval timer on a programmed I/O bus.
// Assumes: Bus strobes are one-cycle pulses on clk_i; the external
//    trigger is asynchronous.
// Notes: Control bit n of the bus word sits at vector index 15-n.
//    Reset leaves the timer halted with every mode off; the host must
//    clear the halt bit before any counting starts.
//    Ticks are 50 cycles of the 50 MHz clock, one per microsecond.
`timescale 1ns/100ps
`include "interval_timer_consts.vh"

module interval_timer_16bit (
   input wire clk_i,
   input wire rst_n_i,
   input wire io_bus_reset_all_i,
   input wire start_strobe_i,
   input wire clear_strobe_i,
   input wire aux_pulse_i,
   input wire out_port_a_write_i,
   input wire out_port_c_write_i,
   input wire in_port_a_read_i,
   input wire in_port_c_read_i,
   input wire [15:0] data_i,
   input wire int_disable_i,
   input wire ext_trigger_i,
   output wire [15:0] data_o,
   output wire data_valid_o,
   output wire busy_o,
   output wire done_o,
   output wire int_req_o,
   output wire overflow_o,
   output wire [15:0] count_o
);

   // Next counter value on a tick, with the wrap folded in
   function [16:0] count_step;
      input [15:0] value;
      begin
         count_step = {1'b0, value} + 17'h0_0001;
      end
   endfunction

   // Keep only implemented control bits
   function [15:0] ctl_clean;
      input [15:0] value;
      begin
         ctl_clean = value & `CTL_USED_MASK;
      end
   endfunction

   reg [15:0] count_preset_q;
   reg [15:0] count_preset_d;
   reg [15:0] timer_control_q;
   reg [15:0] timer_control_d;
   reg [15:0] count_sample_q;
   reg [15:0] count_sample_d;
   reg [15:0] count_q;
   reg [15:0] count_d;
   reg [`TICK_CNT_W-1:0] tick_cnt_q;
   reg [`TICK_CNT_W-1:0] tick_cnt_d;
   reg tick_q;
   reg tick_d;
   reg busy_q;
   reg busy_d;
   reg done_q;
   reg done_d;
   reg int_req_q;
   reg int_req_d;
   reg overflow_q;
   reg overflow_d;
   reg [15:0] data_q;
   reg [15:0] data_d;
   reg data_valid_q;
   reg data_valid_d;

   // Three-stage synchroniser for the asynchronous trigger
   reg trig_s1_q;
   reg trig_s2_q;
   reg trig_s3_q;
   reg trig_level_q;
   reg trig_level_d;
   reg trig_edge;

   wire [16:0] step;
   wire wrap;
   wire running;
   wire ovf_event;
   wire aux_zero_hit;
   wire aux_load_hit;
   wire ext_load_hit;
   wire count_hit;

   // Control word map (vector index, control bit in brackets):
   //   0 [15] halt when set, run when clear
   //   1 [14] aux pulse zeroes the counter
   //   2 [13] aux pulse loads the preset, unless index 3 is set
   //   3 [12] aux pulse samples the counter; also gates port A reads
   //   4 [11] halt on overflow
   //   5 [10] reload the preset on overflow
   //   6 [9]  external trigger loads the preset
   //   7-15 [8-0] unused, always read as zero

   // Last count of the timebase divider; the divider never stops, so a
   // freshly loaded counter may see its first tick early
   localparam [`TICK_CNT_W-1:0] TICK_LAST = `TICK_LAST;

   assign step = count_step(count_q);
   assign running = ~timer_control_q[`CTL_HALT];
   assign wrap = step[16];
   // Loads outrank counting; an overflow is only flagged when the
   // counter really steps past 65535 in that cycle
   assign aux_zero_hit = aux_pulse_i & timer_control_q[`CTL_AUX_ZERO];
   assign aux_load_hit = aux_pulse_i & ~timer_control_q[`CTL_READ_SEL] &
      timer_control_q[`CTL_AUX_LOAD];
   assign ext_load_hit = trig_edge & timer_control_q[`CTL_EXT_LOAD];
   assign count_hit = tick_q & running & ~aux_zero_hit & ~aux_load_hit &
      ~ext_load_hit;
   assign ovf_event = count_hit & wrap;

   // Microsecond timebase; free running so ticks stay evenly spaced
   always @* begin
      if (tick_cnt_q == TICK_LAST) begin
         tick_cnt_d = {`TICK_CNT_W{1'b0}};
         tick_d = 1'b1;
      end else begin
         tick_cnt_d = tick_cnt_q + 1'b1;
         tick_d = 1'b0;
      end
   end

   // A change counts only once the second and third stages agree
   always @* begin
      trig_level_d = trig_level_q;
      trig_edge = 1'b0;
      if (trig_s2_q == trig_s3_q) begin
         trig_level_d = trig_s3_q;
         trig_edge = trig_s3_q & ~trig_level_q;
      end
   end

   // The preset is only ever written by the host; loads copy it out
   // and leave it in place
   always @* begin
      count_preset_d = count_preset_q;
      if (out_port_a_write_i) begin
         count_preset_d = data_i;
      end
   end

   // Host writes land any time; stop on overflow wins over a write
   always @* begin
      timer_control_d = timer_control_q;
      if (out_port_c_write_i) begin
         timer_control_d = ctl_clean(data_i);
      end
      if (ovf_event && timer_control_q[`CTL_OVF_STOP]) begin
         timer_control_d[`CTL_HALT] = 1'b1;
      end
   end

   // Sampling only copies the counter, it never writes it back
   always @* begin
      count_sample_d = count_sample_q;
      if (aux_pulse_i && timer_control_q[`CTL_READ_SEL]) begin
         count_sample_d = count_q;
      end
   end

   // Counter priority: zero, aux load, trigger load, then counting
   always @* begin
      count_d = count_q;
      if (aux_zero_hit) begin
         count_d = `COUNT_ZERO;
      end else if (aux_load_hit) begin
         count_d = count_preset_q;
      end else if (ext_load_hit) begin
         count_d = count_preset_q;
      end else if (count_hit) begin
         if (wrap && timer_control_q[`CTL_OVF_LOAD]) begin
            count_d = count_preset_q;
         end else begin
            count_d = step[15:0];
         end
      end
   end

   // Busy/done follow the host's standard completion protocol. Done is
   // set by hardware, and that set wins over a start, clear or bus reset
   // strobe in the same cycle so an overflow is never lost. Busy itself
   // never gates counting; it only decides whether an overflow completes.
   always @* begin
      busy_d = busy_q;
      done_d = done_q;
      if (start_strobe_i) begin
         busy_d = 1'b1;
         done_d = 1'b0;
      end
      if (clear_strobe_i || io_bus_reset_all_i) begin
         busy_d = 1'b0;
         done_d = 1'b0;
      end
      if (ovf_event && busy_q) begin
         busy_d = 1'b0;
         done_d = 1'b1;
      end
   end

   // The disable input only masks the request; done stays set, so a
   // later enable still raises the interrupt
   always @* begin
      int_req_d = done_d & ~int_disable_i;
      overflow_d = ovf_event;
   end

   // Read data is held until the next read strobe
   // A port C read wins over a port A read in the same cycle
   always @* begin
      data_d = data_q;
      data_valid_d = 1'b0;
      if (in_port_c_read_i) begin
         data_d = timer_control_q;
         data_valid_d = 1'b1;
      end else if (in_port_a_read_i) begin
         if (timer_control_q[`CTL_READ_SEL]) begin
            data_d = count_sample_q;
            data_valid_d = 1'b1;
         end else begin
            data_d = 16'h0000;
            data_valid_d = 1'b0;
         end
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         trig_s1_q <= 1'b0;
         trig_s2_q <= 1'b0;
         trig_s3_q <= 1'b0;
      end else begin
         trig_s1_q <= ext_trigger_i;
         trig_s2_q <= trig_s1_q;
         trig_s3_q <= trig_s2_q;
      end
   end

   // Level resets low, the idle level of the pin, so no false edge
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         trig_level_q <= 1'b0;
      end else begin
         trig_level_q <= trig_level_d;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         tick_cnt_q <= {`TICK_CNT_W{1'b0}};
         tick_q <= 1'b0;
      end else begin
         tick_cnt_q <= tick_cnt_d;
         tick_q <= tick_d;
      end
   end

   // Host-visible registers and the counter itself
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         count_q <= `COUNT_ZERO;
         count_preset_q <= `PRESET_RESET;
         timer_control_q <= `CTL_RESET;
         count_sample_q <= `SAMPLE_RESET;
      end else begin
         count_q <= count_d;
         count_preset_q <= count_preset_d;
         timer_control_q <= timer_control_d;
         count_sample_q <= count_sample_d;
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         int_req_q <= 1'b0;
         overflow_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         done_q <= done_d;
         int_req_q <= int_req_d;
         overflow_q <= overflow_d;
      end
   end

   // Read port; data stays put between reads
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         data_q <= 16'h0000;
         data_valid_q <= 1'b0;
      end else begin
         data_q <= data_d;
         data_valid_q <= data_valid_d;
      end
   end

   assign data_o = data_q;
   assign data_valid_o = data_valid_q;
   assign busy_o = busy_q;
   assign done_o = done_q;
   assign int_req_o = int_req_q;
   assign overflow_o = overflow_q;
   assign count_o = count_q;

endmodule // interval_timer_16bit

/* sim/interval_timer_16bit_monitor.sv */
// Purpose: Port-level checks for the interval timer.
// Assumes: Control register contents are not visible here.
// Notes: Bound from the bench top file.
`timescale 1ns/100ps
module interval_timer_16bit_monitor (
   input wire clk_i,
   input wire rst_n_i,
   input wire start_strobe_i,
   input wire clear_strobe_i,
   input wire in_port_a_read_i,
   input wire in_port_c_read_i,
   input wire int_disable_i,
   input wire [15:0] data_o,
   input wire data_valid_o,
   input wire busy_o,
   input wire done_o,
   input wire int_req_o,
   input wire overflow_o,
   input wire [15:0] count_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_ctl_read: assert property (in_port_c_read_i |=> data_valid_o)
      else $error("control read without valid");
   a_unused_zero: assert property (
      in_port_c_read_i |=> data_o[15:7] == 9'h000)
      else $error("unused control bits not zero");
   a_valid_cause: assert property (
      data_valid_o |-> $past(in_port_a_read_i || in_port_c_read_i))
      else $error("valid pulse without read");
   a_start_busy: assert property (start_strobe_i |=> busy_o != done_o)
      else $error("start did not set busy");
   a_clear_idle: assert property (clear_strobe_i |=> !busy_o)
      else $error("clear left busy set");
   a_busy_done: assert property (!(busy_o && done_o))
      else $error("busy and done both set");
   a_int_lag: assert property (
      int_req_o == (done_o && !$past(int_disable_i)))
      else $error("interrupt request mismatch");
   a_ovf_single: assert property (overflow_o |=> !overflow_o)
      else $error("overflow pulse too long");
   a_wrap_ovf: assert property (
      $past(count_o) == 16'hFFFF && count_o == 16'h0000 |-> ##[0:1] overflow_o)
      else $error("wrap without overflow");
endmodule // interval_timer_16bit_monitor

/* sim/host_pio_model.sv */
// Purpose: Host programmed I/O model issuing timer strobes.
// Assumes: Strobe bits {io_bus_reset_all,start,clear,aux,wa,wc,ra,rc}.
// Notes: Released data shows the inverse of the last word.
`timescale 1ns/100ps
module host_pio_model (
   input wire clk_i,
   input wire [15:0] rd_i,
   input wire vld_i,
   output reg [7:0] st_o,
   output reg [15:0] d_o
);
   initial begin
      st_o = 8'h00;
      d_o = 16'h0000;
   end
   task op(input [7:0] s, input [15:0] d);
      begin
         @(posedge clk_i);
         st_o <= s;
         d_o <= d;
         @(posedge clk_i);
         st_o <= 8'h00;
         d_o <= ~d;
         #1;
      end
   endtask
   task rd(input [7:0] s, output [15:0] v, output ok);
      begin
         op(s, 16'h0000);
         v = rd_i;
         ok = vld_i;
      end
   endtask
   // Preset 65536-T, load it while halted, start, then run
   task arm(input [15:0] t, input [15:0] c);
      begin
         op(8'h08, 16'h0000 - t);
         op(8'h04, 16'h0005);
         op(8'h10, 16'h0000);
         op(8'h40, 16'h0000);
         op(8'h04, c);
      end
   endtask
endmodule // host_pio_model

/* sim/interval_timer_16bit_bench.sv */
// Purpose: Self-checking bench for the interval timer.
// Assumes: 20 ns clock, so one count is 50 cycles.
// Notes: Waits are bounded; a timeout ends the run.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks = num_checks + 1; \
   if ((a) !== (e)) begin error_cnt = error_cnt + 1; \
   $display("wrong value at %0t: %h not %h", $time, a, e); end end
module interval_timer_16bit_bench;
   reg clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg ext_trigger_i = 1'b0;
   reg int_disable_i = 1'b0;
   wire [7:0] st;
   wire [15:0] data_i, data_o, count_o;
   wire io_bus_reset_all_i, start_strobe_i, clear_strobe_i, aux_pulse_i;
   wire out_port_a_write_i, out_port_c_write_i, in_port_a_read_i;
   wire in_port_c_read_i, data_valid_o, busy_o, done_o, int_req_o;
   wire overflow_o;
   reg [15:0] v;
   reg ok;
   integer error_cnt = 0, num_checks = 0, i;
   assign {io_bus_reset_all_i, start_strobe_i, clear_strobe_i, aux_pulse_i,
      out_port_a_write_i, out_port_c_write_i, in_port_a_read_i,
      in_port_c_read_i} = st;
   always #10 clk_i = ~clk_i;
   interval_timer_16bit dut (.*);
   host_pio_model host (.clk_i(clk_i), .rd_i(data_o), .vld_i(data_valid_o),
      .st_o(st), .d_o(data_i));
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", num_checks, error_cnt);
         if (error_cnt == 0 && num_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task wait_ovf;
      begin
         i = 0;
         while (overflow_o !== 1'b1 && i < 400) begin
            @(posedge clk_i);
            #1;
            i = i + 1;
         end
         if (overflow_o !== 1'b1) begin
            error_cnt = error_cnt + 1;
            report_and_stop;
         end
      end
   endtask
   task ctl(input [15:0] e);
      begin
         host.rd(8'h01, v, ok);
         `CHK(v, e)
      end
   endtask
   task aux_do(input [15:0] c);
      begin
         host.op(8'h04, c);
         host.op(8'h10, 16'h0000);
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_n_i <= 1'b1;
      ctl(16'h0001);
      host.op(8'h04, 16'hFFFF);
      ctl(16'h007F);
      host.op(8'h08, 16'h1234);
      aux_do(16'h0005);
      `CHK(count_o, 16'h1234)
      aux_do(16'h0003);
      `CHK(count_o, 16'h0000)
      aux_do(16'h0005);
      `CHK(count_o, 16'h1234)
      aux_do(16'h0009);
      host.rd(8'h02, v, ok);
      `CHK(v, 16'h1234)
      host.op(8'h04, 16'h0001);
      host.rd(8'h02, v, ok);
      `CHK(ok, 1'b0)
      aux_do(16'h0003);
      host.op(8'h04, 16'h0041);
      @(posedge clk_i) ext_trigger_i <= 1'b1;
      repeat (8) @(posedge clk_i);
      #1 `CHK(count_o, 16'h1234)
      aux_do(16'h0043);
      repeat (8) @(posedge clk_i);
      #1 `CHK(count_o, 16'h0000)
      @(posedge clk_i) ext_trigger_i <= 1'b0;
      host.arm(16'h0002, 16'h0000);
      wait_ovf;
      `CHK(done_o, 1'b1)
      @(posedge clk_i);
      #1 `CHK(int_req_o, 1'b1)
      `CHK(count_o, 16'h0000)
      repeat (60) @(posedge clk_i);
      #1 `CHK(count_o, 16'h0001)
      host.op(8'h20, 16'h0000);
      `CHK(done_o, 1'b0)
      @(posedge clk_i) int_disable_i <= 1'b1;
      host.arm(16'h0001, 16'h0030);
      wait_ovf;
      @(posedge clk_i);
      #1 `CHK(int_req_o, 1'b0)
      `CHK(count_o, 16'hFFFF)
      ctl(16'h0031);
      host.op(8'h40, 16'h0000);
      `CHK(busy_o, 1'b1)
      host.op(8'h80, 16'h0000);
      `CHK(busy_o, 1'b0)
      report_and_stop;
   end
endmodule // interval_timer_16bit_bench
bind interval_timer_16bit interval_timer_16bit_monitor mon (.*);
